// File: rtl/iitc_ctrl.sv
// interrupt latch, interval timers and auxiliary drive ports
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE1] test bit bypasses priority, puts internal clock on interrupt output
// [RULE2] rate octuple runs internal clock eight times faster
// [RULE3] acknowledge enable answers ack cycle with opcode, clears that latch
// [RULE4] source select set: rising edge of parallel msb sets request 7
// [RULE5] tick source with select set interrupts every 512 ms
// [RULE6] source select clear: fifth timer zero sets request 7
// [RULE7] break holds transmit line low, apart from the one cycle of a reset pulse
// [RULE8] reset bit restarts receiver search, clears its flags, keeps buffer
// [RULE9] reset bit forces line marking and sets transmit empty
// [RULE10] reset clears latches except transmit request, clears timers, not stored
// [RULE11] vector read returns opcode of highest unmasked pending request
// [RULE12] vector read clears reported latch; none pending reads all ones
// [RULE13] each latch is ANDed with its mask bit before encoding
// [RULE14] latches set regardless of mask and hold until serviced
// [RULE15] mask bits follow the request latch positions
// [RULE16] aux status low bits show sense switches, zero means on
// [RULE17] aux status bit 7 shows data request or 512 ms square wave
// [RULE18] aux status bit 6 high while head motor moves
// [RULE19] aux control bit 5 low forces all four drive selects
// [RULE20] aux bit 1 low selects side 1; bit 2 low asserts spare output
// [RULE21] timers load eight bits, tick down, set latch at zero, stop
// [RULE22] zero load requests at once; reload while running restarts quietly
// [RULE23] transmit empty drives latch 5, receive available drives latch 4
module iitc_ctrl
    import iitc_pkg::*;
#(
    parameter int P_TICK_CYC     = TICK_CYC,
    parameter int P_RTC_HALF_CYC = RTC_HALF_CYC,
    parameter bit P_TICK_FITTED  = 1'b1
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire iitc_bus_s  i_bus,
    input  wire logic       i_int_ack,
    input  wire logic       i_tx_empty,
    input  wire logic       i_rx_available,
    input  wire logic       i_tx_serial,
    input  wire logic       i_disk_job_done,
    input  wire logic       i_disk_data_request,
    input  wire logic       i_timer5_zero,
    input  wire logic       i_seek_moving,
    input  wire logic [4:0] i_sense_sw,
    input  wire logic [3:0] i_fdc_drive_sel,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid,
    output logic [7:0]      o_ack_data,
    output logic            o_ack_valid,
    output logic            o_int,
    output logic            o_txd,
    output logic            o_rx_flags_clr,
    output logic            o_tx_empty_set,
    output logic [3:0]      o_drive_sel,
    output logic            o_side_one,
    output logic            o_control_out_n,
    output logic            o_tick
);

    localparam logic [31:0] HALF_SLOW = 32'(P_TICK_CYC / 2);
    localparam logic [31:0] HALF_FAST = 32'(P_TICK_CYC / (2 * OCTUPLE));
    localparam logic [31:0] RTC_HALF  = 32'(P_RTC_HALF_CYC);

    // lowest pending index wins; bit 8 flags a hit
    function automatic logic [8:0] pick(input logic [7:0] pend);
        logic [8:0] r;
        r = {1'b0, VEC_NONE};
        for (int k = 7; k >= 0; k--) begin
            if (pend[k]) begin
                r = {1'b1, VEC_BASE + 8'(k * 8)};
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] vec_idx(input logic [7:0] v);
        return v[5:3];
    endfunction

    function automatic int tmr_bit(input int t);
        case (t)
            0:       return REQ_TMR1;
            1:       return REQ_TMR2;
            2:       return REQ_TMR3;
            default: return REQ_TMR4;
        endcase
    endfunction

    logic [7:0]  cmd_q;
    logic [7:0]  mask_q;
    logic [7:0]  aux_ctrl_q;
    logic [7:0]  req_q;
    logic [7:0]  req_d;
    logic [7:0]  req_set;
    logic [7:0]  req_clr;
    logic [31:0] div_q;
    logic        iclk_q;
    logic        tick_q;
    logic [31:0] rtc_div_q;
    logic        rtc_q;
    logic        low_src_q;
    logic        rx_q;
    logic        tx_q;
    logic        job_q;
    logic [7:0]  tmr_cnt_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] tmr_run_q;
    logic [NUM_TIMERS-1:0] tmr_fire;

    logic        wr_cmd;
    logic        wr_mask;
    logic        wr_aux;
    logic        rd_vec;
    logic        rd_aux;
    logic        chip_reset_pulse;
    logic        ack_take;
    logic [7:0]  pend;
    logic [8:0]  top;
    logic [31:0] half;
    logic        parallel_in_msb;

    assign wr_cmd  = i_bus.wr && i_bus.addr == ADDR_CMD;
    assign wr_mask = i_bus.wr && i_bus.addr == ADDR_MASK;
    assign wr_aux  = i_bus.wr && i_bus.addr == ADDR_AUX;
    assign rd_vec  = i_bus.rd && i_bus.addr == ADDR_VECTOR;
    assign rd_aux  = i_bus.rd && i_bus.addr == ADDR_AUX;
    assign chip_reset_pulse = wr_cmd && i_bus.wdata[BIT_RESET];
    assign ack_take = i_int_ack && cmd_q[BIT_ACKEN];  // see [RULE3]
    assign pend     = req_q & mask_q;                  // see [RULE13]
    assign top      = pick(pend);                      // see [RULE11]
    // jumper option picks what drives the parallel msb
    assign parallel_in_msb = P_TICK_FITTED ? rtc_q : i_disk_data_request;

    // command port; reset bit is a pulse and never stored
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_q <= RST_CMD;
        end else if (wr_cmd) begin
            cmd_q <= {i_bus.wdata[7:1], 1'b0};  // see [RULE10]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_q <= RST_MASK;
        end else if (wr_mask) begin
            mask_q <= i_bus.wdata;  // see [RULE15]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aux_ctrl_q <= RST_AUX_CTRL;
        end else if (wr_aux) begin
            aux_ctrl_q <= i_bus.wdata;
        end
    end

    // internal clock: half-period divider, eightfold when octupled
    assign half = cmd_q[BIT_OCTUP] ? HALF_FAST : HALF_SLOW;  // see [RULE2]

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q  <= '0;
            iclk_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (div_q + 32'd1 >= half) begin
            div_q  <= '0;
            iclk_q <= !iclk_q;
            tick_q <= !iclk_q;
        end else begin
            div_q  <= div_q + 32'd1;
            tick_q <= 1'b0;
        end
    end

    // board tick: free square wave, independent of octupling
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rtc_div_q <= '0;
            rtc_q     <= 1'b0;
        end else if (rtc_div_q + 32'd1 >= RTC_HALF) begin
            rtc_div_q <= '0;
            rtc_q     <= !rtc_q;  // see [RULE5]
        end else begin
            rtc_div_q <= rtc_div_q + 32'd1;
        end
    end

    // edge detectors for level sources
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_src_q <= 1'b0;
            rx_q      <= 1'b0;
            tx_q      <= 1'b0;
            job_q     <= 1'b0;
        end else begin
            low_src_q <= parallel_in_msb;
            rx_q      <= i_rx_available;
            tx_q      <= i_tx_empty;
            job_q     <= i_disk_job_done;
        end
    end

    // interval timers
    generate
        for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
            logic wr_t;
            assign wr_t = i_bus.wr && i_bus.addr == ADDR_TIMER1 + 8'(t);
            // zero load fires at once; the write cycle never fires from the old count
            assign tmr_fire[t] = (wr_t && i_bus.wdata == 8'h00)  // see [RULE22]
                || (!wr_t && !chip_reset_pulse && tmr_run_q[t]
                    && tick_q && tmr_cnt_q[t] == 8'h01);          // see [RULE21]
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    tmr_cnt_q[t] <= 8'h00;
                    tmr_run_q[t] <= 1'b0;
                end else if (chip_reset_pulse) begin
                    tmr_cnt_q[t] <= 8'h00;  // see [RULE10]
                    tmr_run_q[t] <= 1'b0;
                end else if (wr_t) begin
                    tmr_cnt_q[t] <= i_bus.wdata;  // see [RULE22]
                    tmr_run_q[t] <= i_bus.wdata != 8'h00;
                end else if (tmr_run_q[t] && tick_q) begin
                    tmr_cnt_q[t] <= tmr_cnt_q[t] - 8'h01;  // see [RULE21]
                    tmr_run_q[t] <= tmr_cnt_q[t] != 8'h01;
                end
            end
        end
    endgenerate

    // request sets and clears
    always_comb begin
        req_set = '0;
        for (int t = 0; t < NUM_TIMERS; t++) begin
            req_set[tmr_bit(t)] = tmr_fire[t];  // see [RULE21]
        end
        req_set[REQ_JOB] = i_disk_job_done && !job_q;
        req_set[REQ_RX]  = i_rx_available && !rx_q;  // see [RULE23]
        req_set[REQ_TX]  = i_tx_empty && !tx_q;      // see [RULE23]
        if (cmd_q[BIT_SRCSEL]) begin
            req_set[REQ_LOW] = parallel_in_msb && !low_src_q;  // see [RULE4]
        end else begin
            req_set[REQ_LOW] = i_timer5_zero;  // see [RULE6]
        end
        req_clr = '0;
        if (rd_vec && top[8]) begin
            req_clr[vec_idx(top[7:0])] = 1'b1;  // see [RULE12]
        end
        if (ack_take && top[8]) begin
            req_clr[vec_idx(top[7:0])] = 1'b1;  // see [RULE3]
        end
    end

    // a set arriving with a clear wins; mask never gates the latch
    always_comb begin
        if (chip_reset_pulse) begin
            req_d = TX_REQ_ONLY | req_set;  // see [RULE10]
        end else begin
            req_d = (req_q & ~req_clr) | req_set;  // see [RULE14]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q <= RST_REQ;
        end else begin
            req_q <= req_d;
        end
    end

    // register reads
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata  <= IDLE_RD;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= rd_vec || rd_aux;
            if (rd_vec) begin
                o_rdata <= top[7:0];  // see [RULE11] [RULE12]
            end else if (rd_aux) begin
                o_rdata <= {parallel_in_msb,  // see [RULE17]
                            i_seek_moving,    // see [RULE18]
                            1'b0,
                            i_sense_sw[4],    // see [RULE16]
                            i_sense_sw[0], i_sense_sw[1],
                            i_sense_sw[2], i_sense_sw[3]};
            end else begin
                o_rdata <= IDLE_RD;
            end
        end
    end

    // acknowledge answer
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack_data  <= VEC_NONE;
            o_ack_valid <= 1'b0;
        end else begin
            o_ack_valid <= ack_take;  // see [RULE3]
            if (ack_take) begin
                o_ack_data <= top[7:0];
            end
        end
    end

    // interrupt pin; test mode shows raw internal clock
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_int <= 1'b0;
        end else if (cmd_q[BIT_TEST]) begin
            o_int <= iclk_q;  // see [RULE1]
        end else begin
            o_int <= |(req_d & mask_q);
        end
    end

    // receiver and transmitter reset pulses
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_flags_clr <= 1'b0;
            o_tx_empty_set <= 1'b0;
        end else begin
            o_rx_flags_clr <= chip_reset_pulse;  // see [RULE8]
            o_tx_empty_set <= chip_reset_pulse;  // see [RULE9]
        end
    end

    // serial line; reset pulse outranks break, so a reset marks for one cycle before a stored break
    // break comes from the stored bit, so spacing starts one cycle after the write
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_txd <= 1'b1;
        end else if (chip_reset_pulse) begin
            o_txd <= 1'b1;  // see [RULE9]
        end else if (cmd_q[BIT_BREAK]) begin
            o_txd <= 1'b0;  // see [RULE7]
        end else begin
            o_txd <= i_tx_serial;
        end
    end

    // drive pins follow the control port one cycle later
    // override is meant for testing; it forces every select whatever the disk core wants
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drive_sel <= 4'h0;
        end else if (!aux_ctrl_q[BIT_OVRD_N]) begin
            o_drive_sel <= 4'hf;  // see [RULE19]
        end else begin
            o_drive_sel <= i_fdc_drive_sel;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_side_one      <= 1'b0;
            o_control_out_n <= 1'b1;
        end else begin
            o_side_one      <= !aux_ctrl_q[BIT_SIDE_N];  // see [RULE20]
            o_control_out_n <= aux_ctrl_q[BIT_CTRL_N];   // see [RULE20]
        end
    end

    // tick pulse is for observation only; the timers use tick_q directly
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= tick_q;
        end
    end

endmodule // iitc_ctrl

`default_nettype wire

// File: rtl/iitc_pkg.sv
// shared constants and types of the interrupt and interval timer controller
package iitc_pkg;
    // port addresses
    localparam logic [7:0] ADDR_CMD      = 8'h02;
    localparam logic [7:0] ADDR_VECTOR   = 8'h03;
    localparam logic [7:0] ADDR_MASK     = 8'h03;
    localparam logic [7:0] ADDR_AUX      = 8'h04;
    localparam logic [7:0] ADDR_TIMER1   = 8'h05;
    localparam int         NUM_TIMERS    = 4;
    // command port fields
    localparam int BIT_TEST   = 5;
    localparam int BIT_OCTUP  = 4;
    localparam int BIT_ACKEN  = 3;
    localparam int BIT_SRCSEL = 2;
    localparam int BIT_BREAK  = 1;
    localparam int BIT_RESET  = 0;
    // request latch positions
    localparam int REQ_TMR1 = 0;
    localparam int REQ_TMR2 = 1;
    localparam int REQ_JOB  = 2;
    localparam int REQ_TMR3 = 3;
    localparam int REQ_RX   = 4;
    localparam int REQ_TX   = 5;
    localparam int REQ_TMR4 = 6;
    localparam int REQ_LOW  = 7;
    // aux control fields, active low
    localparam int BIT_SIDE_N  = 1;
    localparam int BIT_CTRL_N  = 2;
    localparam int BIT_OVRD_N  = 5;
    // aux status fields
    localparam int BIT_STAT_X7   = 7;
    localparam int BIT_STAT_SEEK = 6;
    // reset values
    localparam logic [7:0] RST_CMD      = 8'h00;
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_AUX_CTRL = 8'hff;
    localparam logic [7:0] RST_REQ      = 8'h00;
    localparam logic [7:0] TX_REQ_ONLY  = 8'h20;
    // restart opcodes
    localparam logic [7:0] VEC_BASE = 8'hc7;
    localparam logic [7:0] VEC_NONE = 8'hff;
    localparam logic [7:0] IDLE_RD  = 8'hff;
    // timing
    localparam int CLK_MHZ      = 100;
    localparam int TICK_US      = 64;
    localparam int OCTUPLE      = 8;
    localparam int RTC_MS       = 512;
    localparam int TICK_CYC     = TICK_US * CLK_MHZ;
    localparam int RTC_HALF_CYC = RTC_MS * 1000 * CLK_MHZ / 2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iitc_bus_s;
endpackage : iitc_pkg

// File: testbench/iitc_chk.sv
// assertion checker of the interrupt and timer controller ports
`timescale 1ns/1ps
`default_nettype none
module iitc_chk
    import iitc_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire iitc_bus_s  i_bus,
    input wire logic       i_int_ack,
    input wire logic       i_seek_moving,
    input wire logic [4:0] i_sense_sw,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rvalid,
    input wire logic       o_ack_valid,
    input wire logic       o_txd,
    input wire logic       o_rx_flags_clr,
    input wire logic       o_tx_empty_set,
    input wire logic [3:0] o_drive_sel,
    input wire logic       o_side_one,
    input wire logic       o_control_out_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic cmd_wr = i_bus.wr && i_bus.addr == ADDR_CMD;
    wire logic aux_wr = i_bus.wr && i_bus.addr == ADDR_AUX;
    wire logic rd_vec = i_bus.rd && i_bus.addr == ADDR_VECTOR;
    wire logic rd_aux = i_bus.rd && i_bus.addr == ADDR_AUX;
    vec_form_a: assert property (rd_vec |=> o_rvalid && o_rdata[2:0] == 3'h7
        && o_rdata[7:6] == 2'h3) else $error("vector read malformed");
    unmapped_rd_a: assert property (i_bus.rd && !rd_vec && !rd_aux
        |=> !o_rvalid) else $error("read of unmapped port answered");
    aux_status_a: assert property (rd_aux |=> o_rvalid
        && o_rdata[6:0] == {$past(i_seek_moving), 1'b0, $past(i_sense_sw[4]),
        $past(i_sense_sw[0]), $past(i_sense_sw[1]), $past(i_sense_sw[2]), $past(i_sense_sw[3])})
        else $error("aux status wrong");
    // break acts from the stored command bit, one cycle after the write lands
    break_low_a: assert property (cmd_wr && i_bus.wdata[1:0] == 2'b10
        |=> ##1 !o_txd) else $error("break did not space the line");
    reset_mark_a: assert property (cmd_wr && i_bus.wdata[0]
        |=> o_txd && o_rx_flags_clr && o_tx_empty_set)
        else $error("reset pulse effects missing");
    pulse_cause_a: assert property (o_rx_flags_clr
        |-> $past(cmd_wr && i_bus.wdata[0])) else $error("receiver clear without reset write");
    ack_cause_a: assert property (o_ack_valid |-> $past(i_int_ack))
        else $error("ack answer without ack cycle");
    // drive pins lag the control port by one register stage
    sel_override_a: assert property (aux_wr && !i_bus.wdata[5]
        |=> ##1 o_drive_sel == 4'hf) else $error("drive select override failed");
    side_ctrl_a: assert property (aux_wr
        |=> ##1 o_side_one == !$past(i_bus.wdata[1], 2)
        && o_control_out_n == $past(i_bus.wdata[2], 2)) else $error("side or spare wrong");
    cover property (rd_vec ##1 o_rdata != VEC_NONE);
    cover property (o_ack_valid);
    cover property (aux_wr && !i_bus.wdata[5]);
endmodule // iitc_chk
bind iitc_ctrl iitc_chk i_iitc_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(i_bus),
    .i_int_ack(i_int_ack), .i_seek_moving(i_seek_moving), .i_sense_sw(i_sense_sw),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_ack_valid(o_ack_valid), .o_txd(o_txd),
    .o_rx_flags_clr(o_rx_flags_clr), .o_tx_empty_set(o_tx_empty_set),
    .o_drive_sel(o_drive_sel), .o_side_one(o_side_one), .o_control_out_n(o_control_out_n));
`default_nettype wire

// File: testbench/iitc_ctrl_tb.sv
// self-checking bench of the interrupt and timer controller
`timescale 1ns/1ps
`default_nettype none
module iitc_ctrl_tb
    import iitc_pkg::*;
();
    logic       clk = 0, rst_n = 0, ack = 0, txe = 0, rxa = 0, job = 0, t5 = 0, seek = 1;
    logic [4:0] sw = 5'h12;
    logic [3:0] fsel = 4'h5;
    iitc_bus_s  bus;
    wire logic [7:0] rdata, ackd;
    wire logic [3:0] dsel;
    wire logic       rvalid, ackv, intr, txd, rxclr, txset, side, ctrl_n, tick;
    int         error_cnt = 0, total_checks = 0, n;
    logic [7:0] d0, d1;
    logic       v;
    localparam logic [7:0] ADDR_TIMER2 = ADDR_TIMER1 + 8'h01;
    always #5 clk = ~clk;
    iitc_host i_iitc_host (.i_sys_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_bus(bus));
    iitc_ctrl #(.P_TICK_CYC(32), .P_RTC_HALF_CYC(100), .P_TICK_FITTED(1'b1)) i_iitc_ctrl (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_int_ack(ack), .i_tx_empty(txe),
        .i_rx_available(rxa), .i_tx_serial(1'b1), .i_disk_job_done(job),
        .i_disk_data_request(1'b0), .i_timer5_zero(t5), .i_seek_moving(seek),
        .i_sense_sw(sw), .i_fdc_drive_sel(fsel), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_ack_data(ackd), .o_ack_valid(ackv), .o_int(intr), .o_txd(txd),
        .o_rx_flags_clr(rxclr), .o_tx_empty_set(txset), .o_drive_sel(dsel),
        .o_side_one(side), .o_control_out_n(ctrl_n), .o_tick(tick));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] d);
        i_iitc_host.wr(ADDR_CMD, d);
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input logic ev);
        i_iitc_host.rd(a, d0, v);
        chk(d0, e);
        chk({7'h0, v}, {7'h0, ev});
    endtask
    // counts ticks until the interrupt line rises, bounded
    task automatic ticks_to_int(output int c);
        c = 0;
        for (int i = 0; i < 400 && intr !== 1'b1; i++) begin
            step(1);
            if (tick === 1'b1) c++;
        end
    endtask
    // samples the interrupt line for 64 cycles and counts its changes
    task automatic toggles(output int c);
        logic p;
        c = 0;
        // the pin changes source one edge after the command lands
        step(1);
        p = intr;
        repeat (64) begin
            step(1);
            if (intr !== p) c++;
            p = intr;
        end
    endtask
    task automatic endt(input string s);
        $display("test %s finished", s);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        cmd(8'h01);
        i_iitc_host.wr(ADDR_MASK, 8'hff);
        job = 1;
        rxa = 1;
        for (int k = 3; k >= 0; k--) begin
            i_iitc_host.wr(ADDR_TIMER1 + 8'(k), 8'h00);
        end
        step(2);
        for (int k = 0; k < 7; k++) begin
            rd_exp(ADDR_VECTOR, VEC_BASE + 8'(8 * k), 1);
        end
        rd_exp(ADDR_VECTOR, VEC_NONE, 1);
        rd_exp(ADDR_CMD, IDLE_RD, 0);
        endt("priority");
        i_iitc_host.wr(ADDR_MASK, 8'h00);
        i_iitc_host.wr(ADDR_TIMER1, 8'h00);
        step(2);
        chk({7'h0, intr}, 8'h00);
        rd_exp(ADDR_VECTOR, VEC_NONE, 1);
        i_iitc_host.wr(ADDR_MASK, 8'h01);
        step(2);
        chk({7'h0, intr}, 8'h01);
        rd_exp(ADDR_VECTOR, 8'hc7, 1);
        endt("mask");
        i_iitc_host.wr(ADDR_TIMER1, 8'h03);
        ticks_to_int(n);
        chk(8'(n), 8'h03);
        rd_exp(ADDR_VECTOR, 8'hc7, 1);
        i_iitc_host.wr(ADDR_TIMER1, 8'h03);
        @(posedge tick);
        i_iitc_host.wr(ADDR_TIMER1, 8'h03);
        ticks_to_int(n);
        chk(8'(n), 8'h03);
        rd_exp(ADDR_VECTOR, 8'hc7, 1);
        i_iitc_host.wr(ADDR_MASK, 8'hff);
        i_iitc_host.wr(ADDR_TIMER2, 8'h02);
        cmd(8'h01);
        step(100);
        rd_exp(ADDR_VECTOR, 8'hef, 1);
        rd_exp(ADDR_VECTOR, VEC_NONE, 1);
        endt("timers");
        cmd(8'h20);
        toggles(n);
        chk(8'(n), 8'h04);
        cmd(8'h30);
        toggles(n);
        chk(8'(n), 8'h20);
        endt("clock");
        cmd(8'h08);
        i_iitc_host.wr(ADDR_TIMER1, 8'h00);
        step(2);
        ack = 1;
        step(1);
        ack = 0;
        chk({7'h0, ackv}, 8'h01);
        chk(ackd, 8'hc7);
        cmd(8'h00);
        i_iitc_host.wr(ADDR_TIMER1, 8'h00);
        step(2);
        ack = 1;
        step(1);
        ack = 0;
        chk({7'h0, ackv}, 8'h00);
        rd_exp(ADDR_VECTOR, 8'hc7, 1);
        endt("ack");
        t5 = 1;
        step(1);
        t5 = 0;
        step(2);
        chk({7'h0, intr}, 8'h01);
        rd_exp(ADDR_VECTOR, VEC_NONE, 1);
        i_iitc_host.wr(ADDR_MASK, 8'h80);
        cmd(8'h04);
        ticks_to_int(n);
        chk({7'h0, intr}, 8'h01);
        i_iitc_host.rd(ADDR_AUX, d1, v);
        step(98);
        i_iitc_host.rd(ADDR_AUX, d0, v);
        chk({7'h0, d0[7]}, {7'h0, ~d1[7]});
        chk({1'b0, d0[6:0]}, 8'h54);
        endt("sources");
        // break is applied from the stored bit, one cycle after the write
        cmd(8'h02);
        step(1);
        chk({7'h0, txd}, 8'h00);
        cmd(8'h03);
        chk({7'h0, txd}, 8'h01);
        // drive pins lag the control port by one register stage
        i_iitc_host.wr(ADDR_AUX, 8'hd9);
        step(1);
        chk({dsel, side, ctrl_n, 2'b00}, 8'hf8);
        i_iitc_host.wr(ADDR_AUX, 8'hff);
        step(1);
        chk({dsel, side, ctrl_n, 2'b00}, 8'h54);
        endt("lines");
        tally_and_finish();
    end
endmodule // iitc_ctrl_tb
`default_nettype wire

// File: testbench/iitc_host.sv
// host processor model issuing port reads and writes
`timescale 1ns/1ps
`default_nettype none
module iitc_host
    import iitc_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output var iitc_bus_s   o_bus
);
    initial o_bus = '0;
    // strobe held one cycle; an idle edge always separates two requests
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) #1;
        o_bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk) #1;
        o_bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_sys_clk) #1;
        o_bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk) #1;
        o_bus.rd = 1'b0;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule // iitc_host
`default_nettype wire
